/* File: src/vbi_fifo.v */
// Purpose: Word FIFO between the slicer and the data outlets.
// Assumes: One clock; flush empties it in one cycle.
// Notes: Read data always come from the output register.
module vbi_fifo #(
   parameter WIDTH = 16,
   parameter DEPTH = 4,
   parameter AW = 2,
   parameter CW = 8
) (
   input wire ref_clk,
   input wire rst_n,
   input wire flush,
   input wire in_valid,
   output reg in_ready,
   input wire [WIDTH-1:0] in_data,
   output reg out_valid,
   input wire out_ready,
   output reg [WIDTH-1:0] out_data,
   output wire [CW-1:0] count
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr;
   reg [AW-1:0] rd_ptr;
   reg [CW-1:0] mem_cnt;
   reg [CW-1:0] next_mem_cnt;
   wire push = in_valid && in_ready;
   wire load = (!out_valid || out_ready) && (mem_cnt != {CW{1'b0}});

   assign count = mem_cnt + {{(CW-1){1'b0}}, out_valid};

   always @* begin
      next_mem_cnt = mem_cnt;
      if (push && !load)
         next_mem_cnt = mem_cnt + 1'b1;
      else if (load && !push)
         next_mem_cnt = mem_cnt - 1'b1;
   end

   always @(posedge ref_clk) begin
      if (push)
         mem[wr_ptr] <= in_data;
      if (!rst_n || flush) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         mem_cnt <= {CW{1'b0}};
         out_valid <= 1'b0;
         out_data <= {WIDTH{1'b0}};
         in_ready <= 1'b0;
      end else begin
         // Ready is registered, so it looks one word ahead.
         in_ready <= next_mem_cnt < DEPTH;
         mem_cnt <= next_mem_cnt;
         if (push)
            wr_ptr <= (wr_ptr == DEPTH - 1) ? {AW{1'b0}} : wr_ptr + 1'b1;
         if (load) begin
            out_data <= mem[rd_ptr];
            out_valid <= 1'b1;
            rd_ptr <= (rd_ptr == DEPTH - 1) ? {AW{1'b0}} : rd_ptr + 1'b1;
         end else if (out_ready) begin
            out_valid <= 1'b0;
         end
      end
   end
endmodule // vbi_fifo

/* File: src/vbi_slicer_defines.vh */
// Purpose: Shared constants of the slicer control block.
// Assumes: Included by bare name from the control block source.
// Notes: Offsets are register addresses on the host register port.
`ifndef VBI_SLICER_DEFINES_VH
`define VBI_SLICER_DEFINES_VH

// ==========================================================
// Register offsets
`define OFS_STATUS 8'hc6
`define OFS_WORD_COUNT 8'hc7
`define OFS_THRESHOLD 8'hc8
`define OFS_FLUSH 8'hc9
`define OFS_LINE_IRQ 8'hca
`define OFS_SWITCH_LO 8'hcb
`define OFS_SWITCH_HI 8'hcc
`define OFS_ROUTE 8'hcd
`define OFS_AUTO_SETUP 8'hce
`define OFS_FULL_FIELD 8'hcf
`define OFS_MODE_FIRST 8'hd0
`define OFS_MODE_LAST 8'hfb
`define OFS_FIFO_DATA 8'hb0

// ==========================================================
// Reset values
`define RST_THRESHOLD 8'h80
`define RST_LINE_IRQ 8'h00
`define RST_SWITCH_LO 8'h1e
`define RST_SWITCH_HI 2'h0
`define RST_MODE 8'hff
`define MODE_ALL_ONES 8'hff

// ==========================================================
// Field positions
`define ST_OVERFLOW 7
`define ST_EMPTY 6
`define LI_FIELD1 7
`define LI_FIELD2 6
`define ROUTE_HOST 6
`define AUTO_INIT 2
`define AUTO_CLOCK 1
`define AUTO_BIT0 0
`define FF_ENABLE 0
`define MB_FILTER 7
`define MB_TO_FIFO 6
`define MB_BLOCK_ERR 5
`define MB_ECC 4

// ==========================================================
// Line geometry and standard codes
`define FIRST_LINE 10'd6
`define LAST_LINE 10'd27
`define MIN_IRQ_LINE 6'd2
`define MODE_COUNT 44
`define STD_WST_PAL_B 4'h1
`define STD_WST_NTSC 4'h3
`define STD_ECC_MAX 4'h4
`define STD_TTX_LAST 4'h5
`define STD_CC_PAL 4'h6
`define STD_CC_NTSC 4'h7
`define STD_OFF 4'hf
`define STD_RESERVED 4'h0
`define CC_LINE_NTSC 10'd21
`define CC_LINE_PAL 10'd22
`define AUTO_FLAGS 4'hf

`endif

/* File: src/vbi_slicer_fifo_control.v */
// Purpose: Control and status of the vbi_slicer and its data FIFO.
// Assumes: Timing and slicing datapath sit outside; all inputs are
//          synchronous to ref_clk; register port is byte wide.
// Notes: FIFO data reach the video port or the host register port.
// Functional notes
// RL1 - Status flags stay set until host writes one; empty flag is live.
// RL2 - Line that cannot fit is dropped whole and sets overflow flag.
// RL3 - Each of six services raises its own available flag.
// RL4 - Word count register reports occupied FIFO entries in 2-byte words.
// RL5 - Request when count exceeds threshold, default 128, if enabled.
// RL6 - Any write to the flush register empties the FIFO.
// RL7 - Line request when line matches six-bit number, per-field enables.
// RL8 - Line number zero or one never gives a line request.
// RL9 - Next line's standard loads at ten-bit switch pixel position.
// RL10 - Host changes switch position, default 30, only for custom standards.
// RL11 - Host-access bit selects video pins or host reads for FIFO data.
// RL12 - Auto initialization preloads line modes for the colour standard.
// RL13 - Auto-clock bit lets the slicer update bit zero of auto register.
// RL14 - Full-field mode slices active and all-ones lines with full standard.
// RL15 - In full-field mode other line values override the full standard.
// RL16 - One mode register per field for lines 6 to 27.
// RL17 - In caption modes top bit enables null byte filtering.
// RL18 - In teletext modes top bit enables the data filter.
// RL19 - Bit six sends data to registers only or FIFO too; teletext FIFO only.
// RL20 - Bit five keeps erroneous data out of the FIFO.
// RL21 - Bit four enables error correction for standard codes one to four.
// RL22 - Low four bits encode the standard; 1111 means slicing off.
`include "vbi_slicer_defines.vh"

module vbi_slicer_fifo_control #(
   parameter DEPTH = 4,
   parameter AW = 2
) (
   input wire ref_clk,
   input wire rst_n,
   input wire [7:0] reg_addr,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_wdata,
   output reg [7:0] reg_rdata,
   input wire line_start,
   input wire [9:0] cur_line,
   input wire cur_field,
   input wire in_vblank,
   input wire [9:0] pixel_count,
   input wire std_is_pal,
   input wire field_start,
   input wire [7:0] full_field_std,
   input wire [5:0] svc_captured,
   input wire auto_bit0_we,
   input wire auto_bit0_val,
   input wire slice_start,
   input wire [7:0] slice_words,
   input wire slice_valid,
   input wire [15:0] slice_data,
   input wire slice_err,
   output reg slice_ready,
   input wire fifo_irq_en,
   input wire line_irq_en,
   output reg fifo_irq,
   output reg line_irq,
   output reg std_load,
   output reg [3:0] line_std,
   output reg null_filter,
   output reg data_filter,
   output reg to_fifo,
   output reg block_err,
   output reg ecc_en,
   output reg [7:0] video_y,
   output reg video_y_valid
);
   // ==========================================================
   // Registers
   reg [7:0] status;
   reg [7:0] threshold;
   reg [7:0] line_irq_cfg;
   reg [7:0] switch_lo;
   reg [1:0] switch_hi;
   reg host_access;
   reg [7:0] auto_setup;
   reg full_field;
   reg [7:0] line_mode [0:`MODE_COUNT-1];
   reg admit;
   reg byte_sel;
   reg [7:0] eff_mode;
   reg auto_run;
   reg [5:0] auto_idx;
   integer i;

   wire [15:0] fifo_out;
   wire fifo_out_valid;
   wire fifo_in_ready;
   wire [7:0] word_count;
   wire wr_hit = reg_wr;
   wire flush = wr_hit && reg_addr == `OFS_FLUSH;
   wire [7:0] mode_off = reg_addr - `OFS_MODE_FIRST;
   wire mode_addr = reg_addr >= `OFS_MODE_FIRST &&
                    reg_addr <= `OFS_MODE_LAST;
   wire [9:0] line_off = cur_line - `FIRST_LINE;
   wire in_table = cur_line >= `FIRST_LINE && cur_line <= `LAST_LINE;
   wire [5:0] cur_idx = {line_off[4:0], cur_field};
   wire [9:0] switch_pixel = {switch_hi, switch_lo};
   wire [3:0] eff_std = eff_mode[3:0];
   wire is_ttx = eff_std >= `STD_WST_PAL_B && eff_std <= `STD_TTX_LAST;
   wire is_cc = eff_std == `STD_CC_PAL || eff_std == `STD_CC_NTSC;
   wire fifo_pop_host = reg_rd && reg_addr == `OFS_FIFO_DATA &&
                        host_access && fifo_out_valid && byte_sel;
   wire fifo_pop_video = !host_access && fifo_out_valid && byte_sel;
   wire fifo_pop = fifo_pop_host || fifo_pop_video;
   wire push = slice_valid && admit && to_fifo &&
               !(block_err && slice_err); // RL20
   localparam [31:0] DEPTH_WORDS = DEPTH;
   wire [7:0] space = DEPTH_WORDS[7:0] - word_count;
   wire to_fifo_next = is_ttx || eff_mode[`MB_TO_FIFO]; // RL19
   wire drop_event = slice_start && to_fifo_next && slice_words > space;

   // ==========================================================
   // FIFO
   vbi_fifo #(
      .WIDTH(16),
      .DEPTH(DEPTH),
      .AW(AW),
      .CW(8)
   ) u_fifo (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .flush(flush), // RL6
      .in_valid(push),
      .in_ready(fifo_in_ready),
      .in_data(slice_data),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_out),
      .count(word_count)
   );

   // ==========================================================
   // Effective mode of the current line
   always @* begin
      if (in_table) begin
         eff_mode = line_mode[cur_idx];
         if (full_field && eff_mode == `MODE_ALL_ONES) // RL14 RL15
            eff_mode = full_field_std;
      end else if (full_field && !in_vblank) begin
         eff_mode = full_field_std; // RL14
      end else begin
         eff_mode = `MODE_ALL_ONES;
      end
   end

   // ==========================================================
   // Host register writes and auto initialization
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         threshold <= `RST_THRESHOLD;
         line_irq_cfg <= `RST_LINE_IRQ;
         switch_lo <= `RST_SWITCH_LO; // RL10
         switch_hi <= `RST_SWITCH_HI;
         host_access <= 1'b0;
         auto_setup <= 8'h00;
         full_field <= 1'b0;
         auto_run <= 1'b0;
         auto_idx <= 6'h00;
         for (i = 0; i < `MODE_COUNT; i = i + 1)
            line_mode[i] <= `RST_MODE;
      end else begin
         if (wr_hit) begin
            case (reg_addr)
               `OFS_THRESHOLD: threshold <= reg_wdata;
               `OFS_LINE_IRQ: line_irq_cfg <= reg_wdata;
               `OFS_SWITCH_LO: switch_lo <= reg_wdata;
               `OFS_SWITCH_HI: switch_hi <= reg_wdata[1:0];
               `OFS_ROUTE: host_access <= reg_wdata[`ROUTE_HOST];
               `OFS_AUTO_SETUP: auto_setup <= reg_wdata;
               `OFS_FULL_FIELD: full_field <= reg_wdata[`FF_ENABLE];
               default: begin
                  if (mode_addr)
                     line_mode[mode_off[5:0]] <= reg_wdata; // RL16
               end
            endcase
         end
         // The slicer may only touch bit 0 while auto clock is set.
         if (auto_bit0_we && auto_setup[`AUTO_CLOCK] &&
             !(wr_hit && reg_addr == `OFS_AUTO_SETUP))
            auto_setup[`AUTO_BIT0] <= auto_bit0_val; // RL13
         // One register per cycle keeps the preload a single write port.
         if (field_start && auto_setup[`AUTO_INIT] && !auto_run) begin
            auto_run <= 1'b1; // RL12
            auto_idx <= 6'h00;
         end else if (auto_run) begin
            if ((auto_idx[5:1] + `FIRST_LINE) ==
                (std_is_pal ? `CC_LINE_PAL : `CC_LINE_NTSC))
               line_mode[auto_idx] <= {`AUTO_FLAGS, std_is_pal ?
                  `STD_CC_PAL : `STD_CC_NTSC}; // RL12
            else
               line_mode[auto_idx] <= {`AUTO_FLAGS, std_is_pal ?
                  `STD_WST_PAL_B : `STD_WST_NTSC}; // RL12
            auto_idx <= auto_idx + 1'b1;
            if (auto_idx == `MODE_COUNT - 1)
               auto_run <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Status flags
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         status <= 8'h00;
      end else begin
         // A new event in the clearing cycle wins over the clear.
         if (wr_hit && reg_addr == `OFS_STATUS)
            status <= (status & ~reg_wdata) | {drop_event, 1'b0,
               svc_captured}; // RL1 RL3
         else
            status <= status | {drop_event, 1'b0, svc_captured}; // RL3
         status[`ST_EMPTY] <= 1'b0; // RL1
      end
   end

   // ==========================================================
   // Line admission into the FIFO
   always @(posedge ref_clk) begin
      if (!rst_n || flush) begin
         admit <= 1'b0;
      end else if (slice_start) begin
         // Whole line or nothing; later shorter lines still go in.
         admit <= slice_words <= space; // RL2
      end
   end

   // ==========================================================
   // Per-line mode outputs, loaded at the switch pixel
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         std_load <= 1'b0;
         line_std <= `STD_OFF;
         null_filter <= 1'b1;
         data_filter <= 1'b0;
         to_fifo <= 1'b1;
         block_err <= 1'b1;
         ecc_en <= 1'b0;
      end else begin
         std_load <= pixel_count == switch_pixel; // RL9
         if (pixel_count == switch_pixel) begin
            line_std <= eff_std; // RL22
            null_filter <= is_cc && eff_mode[`MB_FILTER]; // RL17
            data_filter <= is_ttx && eff_mode[`MB_FILTER]; // RL18
            to_fifo <= to_fifo_next; // RL19
            block_err <= eff_mode[`MB_BLOCK_ERR]; // RL20
            ecc_en <= eff_mode[`MB_ECC] && eff_std != `STD_RESERVED &&
                      eff_std <= `STD_ECC_MAX; // RL21
         end
      end
   end

   // ==========================================================
   // Interrupt requests
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         fifo_irq <= 1'b0;
         line_irq <= 1'b0;
      end else begin
         fifo_irq <= fifo_irq_en && word_count > threshold; // RL5
         line_irq <= line_start && line_irq_en &&
            cur_line == {4'h0, line_irq_cfg[5:0]} && // RL7
            line_irq_cfg[5:0] >= `MIN_IRQ_LINE && // RL8
            (cur_field ? line_irq_cfg[`LI_FIELD2] :
                         line_irq_cfg[`LI_FIELD1]); // RL7
      end
   end

   // ==========================================================
   // Outlets: video pins or host reads, low byte first
   always @(posedge ref_clk) begin
      if (!rst_n || flush) begin
         byte_sel <= 1'b0;
         video_y <= 8'h00;
         video_y_valid <= 1'b0;
         slice_ready <= 1'b0;
      end else begin
         slice_ready <= fifo_in_ready;
         video_y_valid <= !host_access && fifo_out_valid; // RL11
         if (!host_access && fifo_out_valid)
            video_y <= byte_sel ? fifo_out[15:8] : fifo_out[7:0];
         if ((!host_access && fifo_out_valid) || (reg_rd &&
             reg_addr == `OFS_FIFO_DATA && host_access &&
             fifo_out_valid))
            byte_sel <= ~byte_sel; // RL11
      end
   end

   // ==========================================================
   // Register reads
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `OFS_STATUS: reg_rdata <= {status[7],
               word_count == 8'h00, status[5:0]}; // RL1
            `OFS_WORD_COUNT: reg_rdata <= word_count; // RL4
            `OFS_THRESHOLD: reg_rdata <= threshold;
            `OFS_LINE_IRQ: reg_rdata <= line_irq_cfg;
            `OFS_SWITCH_LO: reg_rdata <= switch_lo;
            `OFS_SWITCH_HI: reg_rdata <= {6'h00, switch_hi};
            `OFS_ROUTE: reg_rdata <= {1'b0, host_access, 6'h00};
            `OFS_AUTO_SETUP: reg_rdata <= auto_setup;
            `OFS_FULL_FIELD: reg_rdata <= {7'h00, full_field};
            `OFS_FIFO_DATA: reg_rdata <= (host_access && fifo_out_valid) ?
               (byte_sel ? fifo_out[15:8] : fifo_out[7:0]) : 8'h00;
            default: reg_rdata <= mode_addr ? line_mode[mode_off[5:0]] :
                                              8'h00;
         endcase
      end
   end
endmodule // vbi_slicer_fifo_control

/* File: tb/vbi_slice_source.sv */
// Purpose: Behavioural slicer datapath feeding sliced lines.
// Assumes: A go pulse starts one line of the given word count.
// Notes: Idle data toggles so stale words are never mistaken.
module vbi_slice_source (
   input wire ref_clk,
   input wire rst_n,
   input wire go,
   input wire [7:0] words,
   input wire [15:0] base,
   input wire slice_ready,
   output reg slice_start = 1'b0,
   output reg [7:0] slice_words = 8'h00,
   output reg slice_valid = 1'b0,
   output reg [15:0] slice_data = 16'h0000,
   output reg slice_err = 1'b0
);
   timeunit 1ns;
   timeprecision 1ns;
   reg [7:0] left = 8'h00;
   reg [15:0] next_word = 16'h0000;
   always @(posedge ref_clk) begin
      slice_start <= 1'b0;
      slice_valid <= 1'b0;
      slice_err <= 1'b0;
      slice_data <= ~slice_data;
      if (!rst_n) begin
         left <= 8'h00;
      end else if (go) begin
         slice_start <= 1'b1;
         slice_words <= words;
         left <= words;
         next_word <= base;
      end else if (left != 8'h00 && slice_ready) begin
         // A word is offered only after ready was seen, never blindly.
         slice_valid <= 1'b1;
         slice_data <= next_word;
         next_word <= next_word + 16'h0001;
         left <= left - 8'h01;
      end
   end
endmodule // vbi_slice_source

/* File: tb/vbi_slicer_fifo_control_bench.sv */
// Purpose: Self-checking bench of the slicer control block.
// Assumes: Four-word FIFO; host reaches registers by pulses.
// Notes: Random values come from one fixed seed.
module vbi_slicer_fifo_control_bench;
   timeunit 1ns;
   timeprecision 1ns;
   reg ref_clk = 1'b0;
   reg rst_n = 1'b0;
   reg [7:0] reg_addr = 8'h00;
   reg reg_wr = 1'b0;
   reg reg_rd = 1'b0;
   reg [7:0] reg_wdata = 8'h00;
   reg line_start = 1'b0;
   reg [9:0] cur_line = 10'd0;
   reg cur_field = 1'b0;
   reg [9:0] pixel_count = 10'd0;
   reg [5:0] svc = 6'h00;
   reg go = 1'b0;
   reg [7:0] words = 8'h00;
   reg [15:0] base = 16'h0000;
   reg fifo_irq_en = 1'b0;
   reg vblank = 1'b1;
   reg pal = 1'b0;
   reg fstart = 1'b0;
   reg bit0_we = 1'b0;
   reg [7:0] ff_std = 8'hff;
   reg line_irq_en = 1'b0;
   wire [7:0] reg_rdata, video_y, slice_words;
   wire [15:0] slice_data;
   wire [3:0] line_std;
   wire slice_ready, slice_start, slice_valid, slice_err, fifo_irq;
   wire line_irq, std_load, video_y_valid, ecc_en, block_err, data_filter;
   wire null_filter, to_fifo;
   integer errors = 0;
   integer comparisons = 0;
   integer i;
   reg [7:0] got, v;
   reg [15:0] w;
   reg [7:0] vq [$];
   always #20 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (video_y_valid) vq.push_back(video_y);
   vbi_slice_source u_src (.ref_clk(ref_clk), .rst_n(rst_n), .go(go),
      .words(words), .base(base), .slice_ready(slice_ready),
      .slice_start(slice_start), .slice_words(slice_words),
      .slice_valid(slice_valid), .slice_data(slice_data),
      .slice_err(slice_err));
   vbi_slicer_fifo_control u_dut (.ref_clk(ref_clk), .rst_n(rst_n),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .line_start(line_start), .cur_line(cur_line),
      .cur_field(cur_field), .in_vblank(vblank),
      .pixel_count(pixel_count), .std_is_pal(pal), .field_start(fstart),
      .full_field_std(ff_std), .svc_captured(svc), .auto_bit0_we(bit0_we),
      .auto_bit0_val(cur_field), .slice_start(slice_start),
      .slice_words(slice_words), .slice_valid(slice_valid),
      .slice_data(slice_data), .slice_err(slice_err),
      .slice_ready(slice_ready), .fifo_irq_en(fifo_irq_en),
      .line_irq_en(line_irq_en), .fifo_irq(fifo_irq),
      .line_irq(line_irq), .std_load(std_load), .line_std(line_std),
      .null_filter(null_filter), .data_filter(data_filter), .to_fifo(to_fifo),
      .block_err(block_err), .ecc_en(ecc_en), .video_y(video_y),
      .video_y_valid(video_y_valid));
   // ====
   // Helpers
   function [7:0] reset_value(input [7:0] a);
      case (a)
         8'hc6: reset_value = 8'h40;
         8'hc8: reset_value = 8'h80;
         8'hcb: reset_value = 8'h1e;
         default: reset_value = (a >= 8'hd0 && a <= 8'hfb) ? 8'hff : 8'h00;
      endcase
   endfunction
   task check(input [15:0] seen, input [15:0] want);
      begin
         comparisons = comparisons + 1;
         if (seen !== want) begin
            errors = errors + 1;
            $display("mismatch at %0t: saw %h want %h", $time, seen, want);
         end
      end
   endtask
   task wr(input [7:0] a, input [7:0] d);
      begin
         @(posedge ref_clk);
         reg_wr <= 1'b1;
         reg_addr <= a;
         reg_wdata <= d;
         @(posedge ref_clk);
         reg_wr <= 1'b0;
      end
   endtask
   task rd(input [7:0] a);
      begin
         @(posedge ref_clk);
         reg_rd <= 1'b1;
         reg_addr <= a;
         @(posedge ref_clk);
         reg_rd <= 1'b0;
         #1 got = reg_rdata;
      end
   endtask
   task send(input [7:0] n, input [15:0] b);
      begin
         @(posedge ref_clk);
         go <= 1'b1;
         words <= n;
         base <= b;
         @(posedge ref_clk);
         go <= 1'b0;
         repeat (n + 6) @(posedge ref_clk);
      end
   endtask
   task pulse_line(input [9:0] n);
      begin
         @(posedge ref_clk);
         line_start <= 1'b1;
         cur_line <= n;
         @(posedge ref_clk);
         line_start <= 1'b0;
         #1 got = {7'h00, line_irq};
      end
   endtask
   task load_std(input [9:0] n, input f, input b);
      begin
         @(posedge ref_clk);
         cur_line <= n;
         cur_field <= f;
         vblank <= b;
         pixel_count <= 10'h000;
         @(posedge ref_clk);
         pixel_count <= 10'h01e;
         @(posedge ref_clk);
         pixel_count <= 10'h01f;
         repeat (3) @(posedge ref_clk);
         #1;
      end
   endtask
   task tally_and_finish;
      begin
         $display("comparisons %0d mismatches %0d", comparisons, errors);
         if (errors == 0 && comparisons > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask
   initial begin
      repeat (5000) @(posedge ref_clk);
      errors = errors + 1;
      $display("mismatch at %0t: watchdog expired", $time);
      tally_and_finish;
   end
   // ====
   // Tests
   initial begin
      v = 8'($urandom(79836));
      repeat (6) @(posedge ref_clk);
      rst_n <= 1'b1;
      for (i = 8'hc6; i <= 8'hfc; i = i + 1) begin
         rd(8'(i));
         check(got, reset_value(8'(i)));
      end
      rd(8'hcb);
      check(got, 8'h1e);
      $display("reset values done");
      wr(8'hcd, 8'h40);
      wr(8'hc8, 8'h01);
      fifo_irq_en <= 1'b1;
      rd(8'hc8);
      check(got, 8'h01);
      w = 16'($urandom);
      send(8'd2, w);
      rd(8'hc7);
      check(got, 8'h02);
      check(fifo_irq, 1'b1);
      send(8'd3, ~w);
      rd(8'hc7);
      check(got, 8'h02);
      rd(8'hc6);
      check(got & 8'hc0, 8'h80);
      send(8'd2, w + 16'h0002);
      rd(8'hc7);
      check(got, 8'h04);
      rd(8'hb0);
      check(got, w[7:0]);
      rd(8'hb0);
      check(got, w[15:8]);
      check(16'(vq.size()), 16'h0000);
      wr(8'hc6, 8'hc0);
      rd(8'hc6);
      check(got & 8'hc0, 8'h00);
      wr(8'hc9, v);
      rd(8'hc7);
      check(got, 8'h00);
      rd(8'hc6);
      check(got & 8'h40, 8'h40);
      check(fifo_irq, 1'b0);
      $display("host access done");
      wr(8'hcd, 8'h00);
      send(8'd1, w);
      check(16'(vq.size()), 16'h0002);
      check(vq[0], w[7:0]);
      check(vq[1], w[15:8]);
      $display("video output done");
      line_irq_en <= 1'b1;
      v = 8'd2 + 8'($urandom_range(25));
      wr(8'hca, 8'h80 | v);
      pulse_line({2'b00, v});
      check(got, 8'h01);
      wr(8'hca, 8'h40 | v);
      pulse_line({2'b00, v});
      check(got, 8'h00);
      wr(8'hca, 8'hc1);
      pulse_line(10'd1);
      check(got, 8'h00);
      $display("line request done");
      for (i = 0; i < 2; i = i + 1) begin
         v = 8'($urandom);
         v[3:0] = i ? 4'h6 + 4'($urandom_range(1)) :
            4'h1 + 4'($urandom_range(3));
         wr(8'hd0 + 8'(3 * i), v);
         load_std(10'd6 + 10'(i), i[0], 1'b1);
         check(line_std, v[3:0]);
         check(ecc_en, v[4] && !i);
         check(block_err, v[5]);
         check(data_filter, v[7] && !i);
         check(null_filter, v[7] && i);
         check(to_fifo, v[6] || !i);
      end
      wr(8'hcf, 8'h01);
      ff_std <= {4'($urandom), 4'h8 + 4'($urandom_range(4))};
      load_std(10'd100, 1'b0, 1'b0);
      check(line_std, ff_std[3:0]);
      load_std(10'd8, 1'b0, 1'b1);
      check(line_std, ff_std[3:0]);
      load_std(10'd7, 1'b1, 1'b1);
      check(line_std, v[3:0]);
      $display("line mode done");
      for (i = 0; i < 6; i = i + 1) begin
         @(posedge ref_clk);
         svc <= 6'h01 << i;
         @(posedge ref_clk);
         svc <= 6'h00;
         rd(8'hc6);
         check(got & (8'h01 << i), 8'h01 << i);
      end
      rd(8'hc6);
      check(got & 8'h3f, 8'h3f);
      wr(8'hc6, 8'h3f);
      rd(8'hc6);
      check(got & 8'h3f, 8'h00);
      $display("service flags done");
      for (i = 0; i < 2; i = i + 1) begin
         wr(8'hce, {6'h00, i[0], 1'b0});
         bit0_we <= 1'b1;
         @(posedge ref_clk);
         bit0_we <= 1'b0;
         rd(8'hce);
         check(got, {6'h00, i[0], i[0]});
      end
      wr(8'hce, 8'h04);
      pal <= 1'($urandom);
      fstart <= 1'b1;
      @(posedge ref_clk);
      fstart <= 1'b0;
      repeat (50) @(posedge ref_clk);
      rd(pal ? 8'hf0 : 8'hee);
      check(got, pal ? 8'hf6 : 8'hf7);
      rd(8'hd0);
      check(got, pal ? 8'hf1 : 8'hf3);
      $display("auto setup done");
      tally_and_finish;
   end
endmodule // vbi_slicer_fifo_control_bench

/* File: tb/vbi_slicer_fifo_control_props.sv */
// Purpose: Port-level checks of the slicer control block.
// Assumes: Bound to every instance of vbi_slicer_fifo_control.
// Notes: One clock domain, so clocking and disable are set once.
module vbi_ctl_props (
   input wire ref_clk,
   input wire rst_n,
   input wire [7:0] reg_addr,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_wdata,
   input wire [7:0] reg_rdata,
   input wire line_start,
   input wire [9:0] cur_line,
   input wire [5:0] svc_captured,
   input wire slice_valid,
   input wire fifo_irq_en,
   input wire line_irq_en,
   input wire fifo_irq,
   input wire line_irq,
   input wire std_load,
   input wire [3:0] line_std,
   input wire ecc_en
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // ====
   // Requests
   chk_low_line_quiet: assert property (
      line_start && cur_line < 10'd2 |=> !line_irq)
      else $error("line request for line zero or one");
   chk_line_cause: assert property (
      line_irq |-> $past(line_start) && $past(line_irq_en))
      else $error("line request without start or enable");
   chk_fifo_irq_gate: assert property (
      fifo_irq |-> $past(fifo_irq_en))
      else $error("threshold request while disabled");
   chk_threshold_rw: assert property (
      reg_wr && reg_addr == 8'hc8 ##1 !reg_wr ##1 reg_rd
      && reg_addr == 8'hc8 |=> reg_rdata == $past(reg_wdata, 3))
      else $error("threshold readback differs");
   // ====
   // FIFO and status
   chk_flush_empty: assert property (
      reg_wr && reg_addr == 8'hc9 && !slice_valid ##1 !slice_valid
      ##1 reg_rd && reg_addr == 8'hc7 && !slice_valid
      |=> reg_rdata == 8'h00)
      else $error("count not zero after flush");
   chk_flag_raised: assert property (
      svc_captured[0] ##2 reg_rd && reg_addr == 8'hc6 |=> reg_rdata[0])
      else $error("available flag missing");
   // ====
   // Line standard
   chk_std_on_load: assert property (
      $changed(line_std) && $past(rst_n) |-> std_load || $past(std_load))
      else $error("standard changed without load");
   chk_ecc_codes: assert property (
      ecc_en |-> line_std inside {4'h1, 4'h2, 4'h3, 4'h4})
      else $error("correction on for wrong code");
   cover property (line_irq);
   cover property (fifo_irq);
   cover property (std_load);
endmodule // vbi_ctl_props

bind vbi_slicer_fifo_control vbi_ctl_props u_props (
   .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
   .reg_rdata(reg_rdata), .line_start(line_start), .cur_line(cur_line),
   .svc_captured(svc_captured), .slice_valid(slice_valid),
   .fifo_irq_en(fifo_irq_en), .line_irq_en(line_irq_en),
   .fifo_irq(fifo_irq), .line_irq(line_irq), .std_load(std_load),
   .line_std(line_std), .ecc_en(ecc_en));
